// ---- design/sfr_flash_dev.sv ----
// Flash device end: command decoder, read engine and byte store.
// Assumes link pins come from another domain and pass two flip-flops.
`timescale 1ns/1ps
`default_nettype none
module sfr_flash_dev import sfr_pkg::*; (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Link
  sfr_link_if.dev                link,
  // Byte store load port
  input  wire logic              mem_we_i,
  input  wire logic [MEM_AW-1:0] mem_addr_i,
  input  wire logic [7:0]        mem_wdata_i,
  // Configuration and protection
  input  wire logic              qio_set_i,
  input  wire logic              lock_bot_i,
  input  wire logic              lock_top_i,
  // Status
  output logic                   quad_mode_o,
  output logic                   cont_mode_o,
  output logic                   qio_en_o,
  output logic [1:0]             burst_code_o
);

  // ==========================================================
  // Pin synchronisers
  logic [5:0] sy1_r;
  logic [5:0] sy2_r;
  logic       sck_d_r;
  logic       cs_d_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sy1_r   <= PIN_IDLE;
      sy2_r   <= PIN_IDLE;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sy1_r   <= {link.cs_n, link.sck, link.sio};
      sy2_r   <= sy1_r;
      sck_d_r <= sy2_r[4];
      cs_d_r  <= sy2_r[5];
    end
  end

  // Edge events on the synchronised pins
  wire       cs_s     = sy2_r[5];
  wire       sck_s    = sy2_r[4];
  wire [3:0] sio_s    = sy2_r[3:0];
  wire       sck_rise = sck_s & ~sck_d_r & ~cs_s;
  wire       sck_fall = ~sck_s & sck_d_r & ~cs_s;
  wire       cs_rise  = cs_s & ~cs_d_r;

  // ==========================================================
  // Decoder state
  sfr_dst_t          st_r;
  logic [4:0]        pcnt_r;
  logic [31:0]       sr_r;
  logic [7:0]        cmd_r;
  logic              op_done_r;
  logic              cont_start_r;
  logic              wq_r;
  logic              hm_r;
  logic              dq_r;
  logic              wrap_r;
  logic [4:0]        alen_r;
  logic [4:0]        dlen_r;
  logic              quad_r;
  logic              cont_r;
  logic              arm_r;
  logic              qio_en_r;
  logic [1:0]        burst_r;
  logic [MEM_AW-1:0] ptr_r;
  logic [2:0]        obit_r;
  logic [7:0]        obyte_r;
  logic [3:0]        sio_o_r;
  logic [3:0]        sio_oe_r;
  logic [7:0]        mem [0:MEM_BYTES-1];

  // Input shift, MSB or high nibble first
  wire [31:0] sr_nxt = wq_r ? {sr_r[27:0], sio_s} : {sr_r[30:0], sio_s[0]};
  wire [4:0]  pc_inc = pcnt_r + 5'h01;
  wire [4:0]  op_len = quad_r ? CLK_OP_X4 : CLK_OP_X1;
  wire [4:0]  bu_len = quad_r ? CLK_BYTE_X4 : CLK_BYTE_X1;
  wire [7:0]  op_byte = sr_nxt[7:0];
  wire        op_last = sck_rise & (st_r == SFR_D_OP) & (pc_inc == op_len);

  // Opcode decode
  wire is_hs    = (op_byte == OP_HSREAD);
  wire is_qo    = (op_byte == OP_QOUT) & qio_en_r & ~quad_r;
  wire is_qio   = (op_byte == OP_QIO) & qio_en_r & ~quad_r;
  wire is_wrap  = (op_byte == OP_WRAPQ) & quad_r;
  wire is_burst = (op_byte == OP_SETBURST);
  wire read_go  = is_hs | is_qo | is_qio | is_wrap;
  wire nq       = quad_r | is_qio;
  wire nhm      = (is_hs & quad_r) | is_qio;
  wire [4:0] nalen = nhm ? CLK_ADDRMODE_X4 : (nq ? CLK_ADDR_X4 : CLK_ADDR_X1);
  wire [4:0] ndlen = is_wrap ? CLK_DUMMY_WRAP : (nq ? CLK_DUMMY_X4 : CLK_DUMMY_X1);

  // Phase end events
  wire addr_end  = sck_rise & (st_r == SFR_D_ADDR) & (pc_inc == alen_r);
  wire burst_end = sck_rise & (st_r == SFR_D_BURST) & (pc_inc == bu_len);
  wire cont_quit = (st_r == SFR_D_ADDR) & cont_start_r & (pcnt_r == CLK_OP_X4)
                   & (sr_r[7:0] == OP_QRESET);

  // ==========================================================
  // Phase sequencer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r         <= SFR_D_OP;
      pcnt_r       <= 5'h00;
      sr_r         <= 32'h0000_0000;
      cmd_r        <= 8'h00;
      op_done_r    <= 1'b0;
      cont_start_r <= 1'b0;
      wq_r         <= 1'b0;
      hm_r         <= 1'b0;
      dq_r         <= 1'b0;
      wrap_r       <= 1'b0;
      alen_r       <= CLK_ADDR_X1;
      dlen_r       <= CLK_DUMMY_X1;
    end else if (cs_s) begin
      // Idle select drops any partial command
      st_r         <= cont_r ? SFR_D_ADDR : SFR_D_OP;
      pcnt_r       <= 5'h00;
      op_done_r    <= 1'b0;
      cont_start_r <= cont_r;
      wq_r         <= cont_r | quad_r;
      hm_r         <= 1'b1;
      dq_r         <= 1'b1;
      wrap_r       <= 1'b0;
      alen_r       <= CLK_ADDRMODE_X4;
      dlen_r       <= CLK_DUMMY_X4;
    end else if (sck_rise) begin
      sr_r   <= sr_nxt;
      pcnt_r <= pc_inc;
      case (st_r)
        SFR_D_OP: if (op_last) begin
          cmd_r     <= op_byte;
          op_done_r <= 1'b1;
          pcnt_r    <= 5'h00;
          st_r      <= read_go ? SFR_D_ADDR : (is_burst ? SFR_D_BURST : SFR_D_IGNORE);
          wq_r      <= nq;
          hm_r      <= nhm;
          dq_r      <= quad_r | is_qo | is_qio;
          wrap_r    <= is_wrap;
          alen_r    <= nalen;
          dlen_r    <= ndlen;
        end
        SFR_D_ADDR: if (pc_inc == alen_r) begin
          pcnt_r <= 5'h00;
          st_r   <= SFR_D_DUMMY;
        end
        SFR_D_DUMMY: if (pc_inc == dlen_r) begin
          st_r <= SFR_D_DATA;
        end
        SFR_D_BURST: if (pc_inc == bu_len) begin
          st_r <= SFR_D_IGNORE;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Protocol, continuous mode, configuration
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      quad_r   <= 1'b0;
      cont_r   <= 1'b0;
      arm_r    <= 1'b0;
      qio_en_r <= 1'b0;
      burst_r  <= BURST_RST;
    end else begin
      if (cs_rise && op_done_r) begin
        arm_r <= (cmd_r == OP_RSTARM);
        case (cmd_r)
          OP_QRESET: quad_r <= 1'b0;
          OP_EQUAD:  quad_r <= 1'b1;
          OP_RST: if (arm_r) begin
            quad_r   <= 1'b0;
            cont_r   <= 1'b0;
            qio_en_r <= 1'b0;
            burst_r  <= BURST_RST;
          end
          default: ;
        endcase
      end
      if (cs_rise && cont_quit) begin
        cont_r <= 1'b0;
      end
      if (addr_end && hm_r) begin
        cont_r <= (sr_nxt[7:4] == CONT_NIB);
      end
      if (burst_end && sr_nxt[7:2] == 6'h00) begin
        burst_r <= sr_nxt[1:0];
      end
      if (qio_set_i) begin
        qio_en_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Byte store and read pointer arithmetic
  always_ff @(posedge clk_i) begin
    if (mem_we_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
  end

  wire [MEM_AW-1:0] ptr_lin  = ptr_r + MEM_AW'(1);
  wire [MEM_AW-1:0] wmask    = (WRAP_MIN << burst_r) - MEM_AW'(1);
  wire [MEM_AW-1:0] ptr_nxt  = wrap_r ? ((ptr_r & ~wmask) | (ptr_lin & wmask)) : ptr_lin;
  wire              locked   = (lock_bot_i & (ptr_r[MEM_AW-1:LOCK_AW] == '0))
                             | (lock_top_i & (&ptr_r[MEM_AW-1:LOCK_AW]));
  wire [7:0]        byte_out = locked ? 8'h00 : mem[ptr_r];

  // ==========================================================
  // Data launch on falling serial clock
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ptr_r    <= '0;
      obit_r   <= 3'h0;
      obyte_r  <= 8'h00;
      sio_o_r  <= 4'h0;
      sio_oe_r <= 4'h0;
    end else if (cs_s) begin
      obit_r   <= 3'h0;
      sio_oe_r <= 4'h0;
    end else if (addr_end) begin
      ptr_r <= hm_r ? sr_nxt[MEM_AW+7:8] : sr_nxt[MEM_AW-1:0];
    end else if (sck_fall && st_r == SFR_D_DATA) begin
      if (obit_r == 3'h0) begin
        sio_oe_r <= dq_r ? 4'hF : 4'h2;
        sio_o_r  <= dq_r ? byte_out[7:4] : {2'b00, byte_out[7], 1'b0};
        obyte_r  <= dq_r ? {byte_out[3:0], 4'h0} : {byte_out[6:0], 1'b0};
        obit_r   <= dq_r ? 3'h1 : 3'h7;
        ptr_r    <= ptr_nxt;
      end else begin
        sio_o_r  <= dq_r ? obyte_r[7:4] : {2'b00, obyte_r[7], 1'b0};
        obyte_r  <= dq_r ? {obyte_r[3:0], 4'h0} : {obyte_r[6:0], 1'b0};
        obit_r   <= obit_r - 3'h1;
      end
    end
  end

  // Outputs
  assign link.d_sio   = sio_o_r;
  assign link.d_oe    = sio_oe_r;
  assign quad_mode_o  = quad_r;
  assign cont_mode_o  = cont_r;
  assign qio_en_o     = qio_en_r;
  assign burst_code_o = burst_r;

endmodule
`default_nettype wire

// ---- design/sfr_flash_host.sv ----
// Flash controller end: frames commands, drives clock, buffers read bytes.
// Assumes the device's quad enable bit was set by its owner before quad reads.
`timescale 1ns/1ps
`default_nettype none
module sfr_flash_host import sfr_pkg::*; (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Link
  sfr_link_if.host        link,
  // Command request
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire sfr_cmd_t   cmd_kind_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [7:0] cmd_mode_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic [7:0] cmd_len_i,
  // Read bytes
  output logic            rd_valid_o,
  input  wire logic       rd_ready_i,
  output logic [7:0]      rd_data_o,
  // Status
  output logic            busy_o,
  output logic            quad_o,
  output logic            cont_o
);

  // ==========================================================
  // Registers
  sfr_hst_t       hst_r;
  logic [3:0]     div_r;
  logic           sck_r;
  logic           cs_n_r;
  logic [HCW-1:0] cnt_r;
  logic [HCW-1:0] n0_r;
  logic [HCW-1:0] txe_r;
  logic [HCW-1:0] dat_r;
  logic [HCW-1:0] tot_r;
  logic           q0_r;
  logic           q1_r;
  logic           rq_r;
  logic [39:0]    tx_r;
  logic [7:0]     rx_r;
  logic [2:0]     rbit_r;
  logic           quad_r;
  logic           cont_r;
  logic           arm_r;
  sfr_cmd_t       kind_r;
  logic [7:0]     mode_r;
  logic [3:0]     sy1_r;
  logic [3:0]     sy2_r;
  logic [7:0]     f0_r;
  logic [7:0]     f1_r;
  logic [1:0]     fcnt_r;

  // ==========================================================
  // Command shape decode
  logic [7:0]  d_op;
  logic [4:0]  d_n0;
  logic [4:0]  d_n1;
  logic [4:0]  d_nd;
  logic        d_q0;
  logic        d_q1;
  logic        d_rq;
  logic [31:0] d_s1;

  always_comb begin
    d_op = OP_QRESET;
    d_n0 = quad_r ? CLK_OP_X4 : CLK_OP_X1;
    d_n1 = 5'h00;
    d_nd = 5'h00;
    d_q0 = quad_r;
    d_q1 = quad_r;
    d_rq = 1'b1;
    d_s1 = {cmd_addr_i, cmd_mode_i};
    case (cmd_kind_i)
      SFR_C_EQUAD:  d_op = OP_EQUAD;
      SFR_C_RSTARM: d_op = OP_RSTARM;
      SFR_C_RST:    d_op = OP_RST;
      SFR_C_HSREAD: begin
        d_op = OP_HSREAD;
        d_n0 = quad_r ? (cont_r ? 5'h00 : CLK_OP_X4) : CLK_OP_X1;
        d_n1 = quad_r ? CLK_ADDRMODE_X4 : CLK_ADDR_X1;
        d_nd = quad_r ? CLK_DUMMY_X4 : CLK_DUMMY_X1;
        d_rq = quad_r;
        d_s1 = quad_r ? {cmd_addr_i, cmd_mode_i} : {cmd_addr_i, 8'h00};
      end
      SFR_C_QOUT: begin
        d_op = OP_QOUT;
        d_n1 = CLK_ADDR_X1;
        d_nd = CLK_DUMMY_X1;
        d_s1 = {cmd_addr_i, 8'h00};
      end
      SFR_C_QIO: begin
        d_op = OP_QIO;
        d_n0 = cont_r ? 5'h00 : CLK_OP_X1;
        d_n1 = CLK_ADDRMODE_X4;
        d_nd = CLK_DUMMY_X4;
        d_q1 = 1'b1;
      end
      SFR_C_BURST: begin
        d_op = OP_SETBURST;
        d_n1 = quad_r ? CLK_BYTE_X4 : CLK_BYTE_X1;
        d_s1 = {cmd_data_i, 24'h000000};
      end
      SFR_C_WRAP: begin
        d_op = OP_WRAPQ;
        d_n1 = CLK_ADDR_X4;
        d_nd = CLK_DUMMY_WRAP;
        d_s1 = {cmd_addr_i, 8'h00};
      end
      default: ;
    endcase
  end

  // Transaction boundaries in serial clocks
  wire           has_rd = (cmd_kind_i == SFR_C_HSREAD) | (cmd_kind_i == SFR_C_QOUT)
                        | (cmd_kind_i == SFR_C_QIO) | (cmd_kind_i == SFR_C_WRAP);
  wire [HCW-1:0] ndat   = !has_rd ? '0 : (d_rq ? {3'b000, cmd_len_i, 1'b0}
                                              : {1'b0, cmd_len_i, 3'b000});
  wire [HCW-1:0] e0     = HCW'(d_n0);
  wire [HCW-1:0] e1     = e0 + HCW'(d_n1);
  wire [HCW-1:0] e2     = e1 + HCW'(d_nd);
  wire           tick   = (div_r == SCK_HALF_LAST);
  wire           cur_q  = (cnt_r < n0_r) ? q0_r : q1_r;
  wire           in_dat = (cnt_r >= dat_r);
  wire           full   = (fcnt_r == 2'h2);
  wire           push   = (hst_r == SFR_H_RUN) & tick & ~sck_r & in_dat & ~full
                        & (rbit_r == (rq_r ? 3'h1 : 3'h7));
  wire           pop    = rd_valid_o & rd_ready_i;
  wire [7:0]     rx_nxt = rq_r ? {rx_r[3:0], sy2_r} : {rx_r[6:0], sy2_r[1]};

  // ==========================================================
  // Sequencer, serial clock divider and shifters
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hst_r  <= SFR_H_IDLE;
      div_r  <= 4'h0;
      sck_r  <= 1'b0;
      cs_n_r <= 1'b1;
      cnt_r  <= '0;
      n0_r   <= '0;
      txe_r  <= '0;
      dat_r  <= '0;
      tot_r  <= '0;
      q0_r   <= 1'b0;
      q1_r   <= 1'b0;
      rq_r   <= 1'b0;
      tx_r   <= 40'h00_0000_0000;
      rx_r   <= 8'h00;
      rbit_r <= 3'h0;
      quad_r <= 1'b0;
      cont_r <= 1'b0;
      arm_r  <= 1'b0;
      kind_r <= SFR_C_QRESET;
      mode_r <= 8'h00;
      sy1_r  <= 4'hF;
      sy2_r  <= 4'hF;
    end else begin
      sy1_r <= link.sio;
      sy2_r <= sy1_r;
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      case (hst_r)
        SFR_H_IDLE: if (cmd_valid_i) begin
          hst_r  <= SFR_H_SEL;
          cs_n_r <= 1'b0;
          cnt_r  <= '0;
          n0_r   <= e0;
          txe_r  <= e1;
          dat_r  <= e2;
          tot_r  <= e2 + ndat;
          q0_r   <= d_q0;
          q1_r   <= d_q1;
          rq_r   <= d_rq;
          tx_r   <= (d_n0 != 5'h00) ? {d_op, d_s1} : {d_s1, 8'h00};
          rbit_r <= 3'h0;
          kind_r <= cmd_kind_i;
          mode_r <= cmd_mode_i;
          div_r  <= 4'h0;
        end
        SFR_H_SEL: if (tick) begin
          hst_r <= SFR_H_RUN;
        end
        SFR_H_RUN: if (tick) begin
          if (!sck_r) begin
            if (!(in_dat && full)) begin
              sck_r <= 1'b1;
              if (in_dat) begin
                rx_r   <= rx_nxt;
                rbit_r <= (rbit_r == (rq_r ? 3'h1 : 3'h7)) ? 3'h0 : rbit_r + 3'h1;
              end
            end
          end else begin
            sck_r <= 1'b0;
            cnt_r <= cnt_r + HCW'(1);
            tx_r  <= cur_q ? {tx_r[35:0], 4'h0} : {tx_r[38:0], 1'b0};
            if (cnt_r + HCW'(1) == tot_r) begin
              hst_r <= SFR_H_DESEL;
            end
          end
        end
        SFR_H_DESEL: if (tick) begin
          cs_n_r <= 1'b1;
          hst_r  <= SFR_H_GAP;
          arm_r  <= (kind_r == SFR_C_RSTARM);
          case (kind_r)
            SFR_C_QRESET: if (cont_r) cont_r <= 1'b0; else quad_r <= 1'b0;
            SFR_C_EQUAD:  quad_r <= 1'b1;
            SFR_C_RST: if (arm_r) begin
              quad_r <= 1'b0;
              cont_r <= 1'b0;
            end
            SFR_C_HSREAD: if (quad_r) cont_r <= (mode_r[7:4] == CONT_NIB);
            SFR_C_QIO:    cont_r <= (mode_r[7:4] == CONT_NIB);
            default: ;
          endcase
        end
        SFR_H_GAP: if (tick) begin
          hst_r <= SFR_H_IDLE;
        end
        default: hst_r <= SFR_H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Two-entry read buffer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      f0_r   <= 8'h00;
      f1_r   <= 8'h00;
      fcnt_r <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (fcnt_r == 2'h0) f0_r <= rx_nxt; else f1_r <= rx_nxt;
          fcnt_r <= fcnt_r + 2'h1;
        end
        2'b01: begin
          f0_r   <= f1_r;
          fcnt_r <= fcnt_r - 2'h1;
        end
        2'b11: f0_r <= (fcnt_r == 2'h1) ? rx_nxt : f1_r;
        default: ;
      endcase
    end
  end

  // Pin drive: upper lines held at defined levels in single-bit mode
  // Frame drive kept through the gap: device releases lines a few cycles late
  wire       act  = (hst_r != SFR_H_IDLE);
  wire       rel  = (cnt_r < dat_r) ? q1_r : rq_r;
  assign link.h_oe  = (act && cnt_r < txe_r) ? 4'hF
                    : (act ? (rel ? 4'h0 : 4'hD) : (quad_r ? 4'h0 : 4'hD));
  assign link.h_sio = cur_q ? tx_r[39:36] : {3'b111, tx_r[39]};
  assign link.cs_n  = cs_n_r;
  assign link.sck   = sck_r;
  assign cmd_ready_o = (hst_r == SFR_H_IDLE);
  assign busy_o      = (hst_r != SFR_H_IDLE);
  assign rd_valid_o  = (fcnt_r != 2'h0);
  assign rd_data_o   = f0_r;
  assign quad_o      = quad_r;
  assign cont_o      = cont_r;

endmodule
`default_nettype wire

// ---- design/sfr_link_if.sv ----
// Serial link between flash controller and flash device.
// Assumes both ends run on the same system clock; lines float high.
`timescale 1ns/1ps
`default_nettype none
interface sfr_link_if;
  // ==========================================================
  // Link wires
  logic       cs_n;
  logic       sck;
  logic [3:0] h_sio;
  logic [3:0] h_oe;
  logic [3:0] d_sio;
  logic [3:0] d_oe;
  logic [3:0] sio;

  // Resolved data lines, undriven lines read high
  assign sio = (h_oe & h_sio) | (d_oe & d_sio) | ~(h_oe | d_oe);

  modport host (output cs_n, sck, h_sio, h_oe, input sio);
  modport dev (input cs_n, sck, sio, output d_sio, d_oe);
endinterface
`default_nettype wire

// ---- design/sfr_pkg.sv ----
// Shared constants and types of the serial flash read engine.
// Assumes one 200 MHz system clock on both ends of the link.
package sfr_pkg;

  // ==========================================================
  // Clocking
  localparam int         CLK_NS        = 5;
  localparam int         SCK_HALF_NS   = 50;
  localparam int         SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_QRESET   = 8'hFF;
  localparam logic [7:0] OP_HSREAD   = 8'h0B;
  localparam logic [7:0] OP_QOUT     = 8'h6B;
  localparam logic [7:0] OP_QIO      = 8'hEB;
  localparam logic [7:0] OP_SETBURST = 8'hC0;
  localparam logic [7:0] OP_WRAPQ    = 8'h0C;
  localparam logic [7:0] OP_EQUAD    = 8'h38;
  localparam logic [7:0] OP_RSTARM   = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;
  localparam logic [3:0] CONT_NIB    = 4'hA;

  // ==========================================================
  // Phase lengths in serial clocks
  localparam logic [4:0] CLK_OP_X1       = 5'h08;
  localparam logic [4:0] CLK_OP_X4       = 5'h02;
  localparam logic [4:0] CLK_ADDR_X1     = 5'h18;
  localparam logic [4:0] CLK_ADDRMODE_X4 = 5'h08;
  localparam logic [4:0] CLK_ADDR_X4     = 5'h06;
  localparam logic [4:0] CLK_DUMMY_X1    = 5'h08;
  localparam logic [4:0] CLK_DUMMY_X4    = 5'h04;
  localparam logic [4:0] CLK_DUMMY_WRAP  = 5'h06;
  localparam logic [4:0] CLK_BYTE_X1     = 5'h08;
  localparam logic [4:0] CLK_BYTE_X4     = 5'h02;

  // ==========================================================
  // Memory, protection, reset values
  localparam int                MEM_AW     = 21;
  localparam int                MEM_BYTES  = 1 << MEM_AW;
  localparam int                LOCK_AW    = 13;
  localparam logic [MEM_AW-1:0] WRAP_MIN   = 21'h000008;
  localparam logic [1:0]        BURST_RST  = 2'h0;
  localparam logic [5:0]        PIN_IDLE   = 6'h2F;
  localparam int                HCW        = 12;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    SFR_C_QRESET, SFR_C_EQUAD, SFR_C_RSTARM, SFR_C_RST, SFR_C_HSREAD,
    SFR_C_QOUT, SFR_C_QIO, SFR_C_BURST, SFR_C_WRAP
  } sfr_cmd_t;

  typedef enum logic [2:0] {
    SFR_D_OP, SFR_D_ADDR, SFR_D_DUMMY, SFR_D_DATA, SFR_D_BURST, SFR_D_IGNORE
  } sfr_dst_t;

  typedef enum logic [2:0] {
    SFR_H_IDLE, SFR_H_SEL, SFR_H_RUN, SFR_H_DESEL, SFR_H_GAP
  } sfr_hst_t;

endpackage

// ---- tb/serial_flash_read_engine_tb.sv ----
// Bench: host and device ends joined by the link.
// Assumes a 200 MHz clock; the bench loads the byte store.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_engine_tb import sfr_pkg::*; ;
  logic        clk_i = 1'b0, rstn_i = 1'b0, cv = 1'b0, rr = 1'b0;
  logic        we = 1'b0, qs = 1'b0, lb = 1'b0, lt = 1'b0;
  sfr_cmd_t    ck = SFR_C_HSREAD;
  logic [23:0] ca = 24'h0;
  logic [7:0]  cm = 8'h0, cl = 8'h0, wd = 8'h0, rd;
  logic [20:0] wa = 21'h0;
  logic        ready, rv, qm, cmo, qe, bsy, hq, hc;
  logic [1:0]  bc;
  int          num_errors = 0, checks_done = 0;
  sfr_link_if lk ();
  // Both ends and the checker
  sfr_flash_host i_sfr_flash_host (.clk_i, .rstn_i, .link(lk.host), .cmd_valid_i(cv),
    .cmd_ready_o(ready), .cmd_kind_i(ck), .cmd_addr_i(ca), .cmd_mode_i(cm), .cmd_data_i(cm),
    .cmd_len_i(cl), .rd_valid_o(rv), .rd_ready_i(rr), .rd_data_o(rd), .busy_o(bsy),
    .quad_o(hq), .cont_o(hc));
  sfr_flash_dev i_sfr_flash_dev (.clk_i, .rstn_i, .link(lk.dev), .mem_we_i(we),
    .mem_addr_i(wa), .mem_wdata_i(wd), .qio_set_i(qs), .lock_bot_i(lb), .lock_top_i(lt),
    .quad_mode_o(qm), .cont_mode_o(cmo), .qio_en_o(qe), .burst_code_o(bc));
  sfr_link_checker i_sfr_link_checker (.clk_i, .rstn_i, .cs_n(lk.cs_n), .sck(lk.sck),
    .h_sio(lk.h_sio), .h_oe(lk.h_oe), .d_sio(lk.d_sio), .d_oe(lk.d_oe));
  // Clock
  always #2.5 clk_i = ~clk_i;
  // ==========================================================
  // Helpers
  function automatic logic [7:0] pat(input logic [20:0] a);
    return a[7:0] ^ {a[20:17], 4'hA};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic idle();
    @(negedge clk_i);
    for (int i = 0; i < 9000 && ready !== 1'b1; i++) @(negedge clk_i);
    chk({7'h0, ready}, 8'h01);
  endtask
  // Status as {quad, continuous, enable, burst}
  task automatic stat(input logic [7:0] e);
    idle();
    chk({1'b0, hq, hc, qm, cmo, qe, bc}, {1'b0, e[4:3], e[4:0]});
  endtask
  task automatic cmd(input sfr_cmd_t k, input logic [23:0] a, input logic [7:0] m, n);
    idle();
    ck = k;
    {ca, cm, cl, cv} = {a, m, n, 1'b1};
    @(negedge clk_i);
    cv = 1'b0;
    chk({6'h0, bsy, lk.cs_n}, 8'h02);
  endtask
  // Read with receiver stalled first, then drained; w is wrap size or 0
  task automatic rdx(input sfr_cmd_t k, input logic [23:0] a, input logic [7:0] m, n,
                     input int w);
    logic [20:0] p;
    p = a[20:0];
    rr = 1'b0;
    cmd(k, a, m, n);
    repeat (1600) @(negedge clk_i);
    chk({7'h0, rv}, 8'h01);
    rr = 1'b1;
    for (int i = 0; i < n; i++) begin
      for (int t = 0; t < 3000 && rv !== 1'b1; t++) @(negedge clk_i);
      chk({7'h0, rv}, 8'h01);
      chk(rd, (lt && p >= 21'h1FE000) || (lb && p < 21'h2000) ? 8'h0 : pat(p));
      p = w ? (p & ~21'(w - 1)) | ((p + 21'h1) & 21'(w - 1)) : p + 21'h1;
      @(negedge clk_i);
    end
    rr = 1'b0;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(negedge clk_i);
    rstn_i = 1'b1;
    for (int i = 0; i < 256; i++) begin
      wa = 21'(i) | (i[7] ? 21'h1FFF00 : 21'h0);
      {we, wd} = {1'b1, pat(wa)};
      @(negedge clk_i);
    end
    we = 1'b0;
    stat(8'h00);
    rdx(SFR_C_HSREAD, 24'h1FFFFE, 8'h0, 8'd4, 0);
    {lt, lb} = 2'h3;
    rdx(SFR_C_HSREAD, 24'h1FFFFF, 8'h0, 8'd2, 0);
    {lt, lb} = 2'h0;
    qs = 1'b1;
    @(negedge clk_i);
    qs = 1'b0;
    stat(8'h04);
    rdx(SFR_C_QOUT, 24'h10, 8'h0, 8'd3, 0);
    rdx(SFR_C_QIO, 24'h20, 8'h0, 8'd3, 0);
    for (int b = 0; b < 4; b++) begin
      cmd(SFR_C_BURST, 24'h0, 8'(b), 8'd0);
      stat(8'h04 | 8'(b));
    end
    cmd(SFR_C_BURST, 24'h0, 8'h13, 8'd0);
    stat(8'h07);
    cmd(SFR_C_EQUAD, 24'h0, 8'h0, 8'd0);
    stat(8'h17);
    rdx(SFR_C_WRAP, 24'h7E, 8'h0, 8'd4, 64);
    rdx(SFR_C_HSREAD, 24'h05, 8'hA0, 8'd2, 0);
    stat(8'h1F);
    rdx(SFR_C_HSREAD, 24'h50, 8'h00, 8'd2, 0);
    stat(8'h17);
    rdx(SFR_C_HSREAD, 24'h60, 8'hA5, 8'd2, 0);
    cmd(SFR_C_QRESET, 24'h0, 8'h0, 8'd0);
    stat(8'h17);
    cmd(SFR_C_QRESET, 24'h0, 8'h0, 8'd0);
    stat(8'h07);
    cmd(SFR_C_RSTARM, 24'h0, 8'h0, 8'd0);
    cmd(SFR_C_RST, 24'h0, 8'h0, 8'd0);
    stat(8'h00);
    // Quad-output read with enable bit clear: device silent, lines read high
    rr = 1'b1;
    cmd(SFR_C_QOUT, 24'h10, 8'h0, 8'd2);
    for (int i = 0; i < 2; i++) begin
      for (int t = 0; t < 3000 && rv !== 1'b1; t++) @(negedge clk_i);
      chk({7'h0, rv}, 8'h01);
      chk(rd, 8'hFF);
      @(negedge clk_i);
    end
    rr = 1'b0;
    stat(8'h00);
    summarize();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire

// ---- tb/sfr_link_checker.sv ----
// Checker for the serial link between host and device ends.
// Assumes one clock; sits beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module sfr_link_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // Link wires
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] h_sio,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_sio,
  input wire logic [3:0] d_oe
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // Steps: high half period, quiet frame start
  sequence hi_half;
    sck [*8] ##1 sck ##1 !sck;
  endsequence
  sequence quiet_start;
    (!sck && d_oe == 4'h0) [*8];
  endsequence
  // Ownership and timing of the wires
  clk_idle_a: assert property (cs_n |-> !sck)
    else $error("clock runs while deselected");
  half_period_a: assert property ($rose(sck) |=> hi_half)
    else $error("high half period not ten cycles");
  quiet_start_a: assert property ($fell(cs_n) |-> quiet_start)
    else $error("frame start not quiet");
  dev_idle_a: assert property (cs_n [*8] |-> d_oe == 4'h0)
    else $error("device drives while deselected");
  fall_launch_a: assert property (!cs_n && d_oe != 4'h0 && $changed(d_sio) |-> !sck)
    else $error("device data moved with clock high");
  host_shift_a: assert property (!cs_n && !$past(cs_n) && $changed(h_sio) |-> !sck)
    else $error("host line moved with clock high");
  upper_lines_a: assert property (d_oe == 4'h2 |-> h_oe[3:2] == 2'h3)
    else $error("upper lines floating");
  no_fight_a: assert property ((h_oe & d_oe) == 4'h0)
    else $error("both ends drive a line");
endmodule
`default_nettype wire
